// [pkg/clock_ctrl_pkg.sv]
package clock_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GATE_A = 10'h063;
  localparam logic [9:0] IDX_GATE_B = 10'h064;
  localparam logic [9:0] IDX_GATE_C = 10'h065;
  localparam logic [9:0] IDX_SYS_SEL = 10'h066;
  localparam logic [9:0] IDX_AUDIO_STEP = 10'h067;
  localparam logic [9:0] IDX_AUDIO_MOD = 10'h068;
  localparam logic [9:0] IDX_MIC_STEP = 10'h06c;
  localparam logic [9:0] IDX_MIC_MOD = 10'h06d;
  localparam logic [9:0] IDX_HS_HIGH = 10'h070;
  localparam logic [9:0] IDX_SLOW_SEL = 10'h073;
  localparam logic [9:0] IDX_STATUS = 10'h074;

  // Values after reset
  localparam logic [7:0] RST_GATE_A = 8'h83;
  localparam logic [7:0] RST_GATE_B = 8'h00;
  localparam logic [7:0] RST_GATE_C = 8'h30;
  localparam logic [7:0] RST_SYS_SEL = 8'h06;
  localparam logic [7:0] RST_AUDIO_STEP = 8'h00;
  localparam logic [7:0] RST_AUDIO_MOD = 8'h02;
  localparam logic [7:0] RST_MIC_STEP = 8'h01;
  localparam logic [7:0] RST_MIC_MOD = 8'h02;
  localparam logic [7:0] RST_HS_HIGH = 8'h00;
  localparam logic [7:0] RST_SLOW_SEL = 8'h04;
  localparam logic [4:0] RST_HS_DIV = 5'h06;
  localparam logic [1:0] RST_SWITCH_SRC = 2'h0;

  // Implemented module gate bits; reserved ones read back but drive nothing
  localparam logic [7:0] GATE_A_MASK = 8'hbf;
  localparam logic [7:0] GATE_B_MASK = 8'h1f;
  localparam logic [7:0] GATE_C_MASK = 8'h37;

  // Field positions
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned SRC_LSB = 5;
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned FHS_LOW_BIT = 7;
  localparam int unsigned FHS_HIGH_BIT = 0;
  localparam int unsigned SLOW_SRC_BIT = 0;
  localparam int unsigned MIC_SRC_BIT = 1;

  // Swallow counter for the 32 MHz option: one tick of three dropped
  localparam logic [1:0] THIRD_LAST = 2'h2;

  // Source switch phases
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD, SW_DROP_NEW} switch_phase_e;

endpackage : clock_ctrl_pkg

// [pkg/frac_if.sv]
`timescale 1ns/1ps
// Fractional divider settings and its output level
interface frac_if;
  logic enable;
  logic [6:0] step;
  logic [7:0] modulus;
  logic ref_tick;
  logic clk_out;
  modport divider (input enable, step, modulus, ref_tick, output clk_out);
  modport control (output enable, step, modulus, ref_tick, input clk_out);
endinterface : frac_if

// [hw/frac_divider.sv]
`timescale 1ns/1ps
module frac_divider
  import clock_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // Settings and output
  frac_if.divider port
);

  typedef struct packed {
    logic [8:0] acc;
    logic out;
    logic run;
  } frac_s;

  frac_s state_reg;
  frac_s state_next;
  logic [9:0] sum;

  // Accumulate 2*step per tick, toggle on each wrap past modulus
  always_comb
  begin
    state_next = state_reg;
    sum = {1'b0, state_reg.acc} + {2'b00, port.step, 1'b0};
    if (port.ref_tick)
    begin
      // Enable only takes hold while the output is low
      if (!state_reg.out)
        state_next.run = port.enable;
      if (state_next.run)
      begin
        if (sum >= {2'b00, port.modulus})
        begin
          state_next.acc = 9'(sum - {2'b00, port.modulus});
          state_next.out = ~state_reg.out;
        end
        else
          state_next.acc = sum[8:0];
      end
      else
        state_next.acc = 9'h000;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= '0;
    else if (clock_en)
      state_reg <= state_next;
  end

  assign port.clk_out = state_reg.out;

endmodule : frac_divider

// [hw/tick_switch.sv]
`timescale 1ns/1ps
module tick_switch
  import clock_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // Source ticks and choice
  input wire logic [3:0] tick_in,
  input wire logic [1:0] sel,
  // Switched tick
  output logic tick_out,
  output logic busy
);

  typedef struct packed {
    logic [1:0] cur;
    switch_phase_e phase;
  } switch_s;

  switch_s state_reg;
  switch_s state_next;

  // Change over after an old tick, then drop the first new tick
  always_comb
  begin
    state_next = state_reg;
    case (state_reg.phase)
      SW_IDLE:
        if (sel != state_reg.cur)
          state_next.phase = SW_WAIT_OLD;
      SW_WAIT_OLD:
        if (tick_in[state_reg.cur])
        begin
          state_next.cur = sel;
          state_next.phase = SW_DROP_NEW;
        end
      SW_DROP_NEW:
        if (tick_in[state_reg.cur])
          state_next.phase = SW_IDLE;
      default:
        state_next.phase = SW_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg.cur <= RST_SWITCH_SRC;
      state_reg.phase <= SW_IDLE;
    end
    else if (clock_en)
      state_reg <= state_next;
  end

  assign tick_out = tick_in[state_reg.cur] &
                    (state_reg.phase != SW_DROP_NEW);
  assign busy = state_reg.phase != SW_IDLE;

endmodule : tick_switch

// [hw/soc_clock_select_and_dividers.sv]
`timescale 1ns/1ps
module soc_clock_select_and_dividers
  import clock_ctrl_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source clocks as one-cycle ticks, one per rising edge
  input wire logic rc24_tick,
  input wire logic xtal24_tick,
  input wire logic ref48_tick,
  // Slow clock sources as sampled levels
  input wire logic rc32k_level,
  input wire logic xtal32k_level,
  // Module clock gates
  output logic [7:0] module_gate_a,
  output logic [7:0] module_gate_b,
  output logic [7:0] module_gate_c,
  // Generated clocks
  output logic high_speed_tick,
  output logic system_tick,
  output logic audio_clock,
  output logic mic_clock,
  output logic slow_clock
);

  typedef struct packed {
    logic [7:0] gate_a;
    logic [7:0] gate_b;
    logic [7:0] gate_c;
    logic [7:0] sys_sel;
    logic [7:0] audio_step;
    logic [7:0] audio_mod;
    logic [7:0] mic_step;
    logic [7:0] mic_mod;
    logic [7:0] hs_high;
    logic [7:0] slow_sel;
    logic [4:0] hs_cnt;
    logic [4:0] hs_div;
    logic [1:0] third_cnt;
    logic slow_src;
    logic slow_out;
    logic mic_src;
    logic mic_out;
    logic rd_fresh;
    logic [31:0] rdata;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;

  frac_if audio_if ();
  frac_if mic_if ();

  logic [3:0] idx;
  logic hit;
  logic wr_stb;
  logic [7:0] wbyte;
  logic [1:0] fhs_code;
  logic hsdiv_tick;
  logic t32_tick;
  logic sys_busy;
  logic fhs_busy;
  logic slow_cand;
  logic mic_cand;
  logic [7:0] status;

  // Map a byte address to a register slot; 4'hf means unmapped
  function automatic logic [3:0] reg_slot(input logic [11:0] a);
    logic [3:0] s;
    s = 4'hf;
    if (a[1:0] == 2'b00)
    begin
      case (a[11:2])
        IDX_GATE_A: s = 4'h0;
        IDX_GATE_B: s = 4'h1;
        IDX_GATE_C: s = 4'h2;
        IDX_SYS_SEL: s = 4'h3;
        IDX_AUDIO_STEP: s = 4'h4;
        IDX_AUDIO_MOD: s = 4'h5;
        IDX_MIC_STEP: s = 4'h6;
        IDX_MIC_MOD: s = 4'h7;
        IDX_HS_HIGH: s = 4'h8;
        IDX_SLOW_SEL: s = 4'h9;
        IDX_STATUS: s = 4'ha;
        default: s = 4'hf;
      endcase
    end
    return s;
  endfunction : reg_slot

  // Next divider count value, shared by the fire test and the counter
  function automatic logic [4:0] next_count(input logic [4:0] c);
    return 5'(c + 5'h01);
  endfunction : next_count

  // A glitch-free mux may move only while both levels are low
  function automatic logic may_switch(input logic cur, input logic want,
                                      input logic out, input logic cand);
    return (cur != want) && !out && !cand;
  endfunction : may_switch

  // Bus decode; waits while frozen, and once more after a frozen setup missed the capture
  assign idx = reg_slot(paddr);
  assign hit = idx != 4'hf;
  assign pready = clock_en & (~psel | ~penable | state_reg.rd_fresh);
  assign pslverr = psel & penable & ~hit;
  assign wr_stb = psel & penable & pready & pwrite & hit;
  assign wbyte = pwdata[7:0];
  assign prdata = state_reg.rdata;

  // High-speed source code and its switch
  assign fhs_code = {state_reg.hs_high[FHS_HIGH_BIT],
                     state_reg.sys_sel[FHS_LOW_BIT]};

  tick_switch u_fhs_switch (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .tick_in({xtal24_tick, xtal24_tick, rc24_tick, ref48_tick}),
    .sel(fhs_code),
    .tick_out(high_speed_tick),
    .busy(fhs_busy)
  );

  // Divider output fires on the tick that completes the count
  assign hsdiv_tick = high_speed_tick &
                      (next_count(state_reg.hs_cnt) >= state_reg.hs_div);

  // Two of every three 48 MHz ticks give the 32 MHz option
  assign t32_tick = ref48_tick & (state_reg.third_cnt != THIRD_LAST);

  tick_switch u_sys_switch (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .tick_in({t32_tick, hsdiv_tick, high_speed_tick, rc24_tick}),
    .sel(state_reg.sys_sel[SRC_LSB+1:SRC_LSB]),
    .tick_out(system_tick),
    .busy(sys_busy)
  );

  // Audio fractional divider from the doubled crystal reference
  assign audio_if.enable = state_reg.audio_step[ENABLE_BIT];
  assign audio_if.step = state_reg.audio_step[6:0];
  assign audio_if.modulus = state_reg.audio_mod;
  assign audio_if.ref_tick = ref48_tick;

  frac_divider u_audio_div (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .port(audio_if.divider)
  );

  // Mic fractional divider
  assign mic_if.enable = state_reg.mic_step[ENABLE_BIT];
  assign mic_if.step = state_reg.mic_step[6:0];
  assign mic_if.modulus = state_reg.mic_mod;
  assign mic_if.ref_tick = ref48_tick;

  frac_divider u_mic_div (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .port(mic_if.divider)
  );

  // Levels of the sources that the slow and mic muxes would switch to
  assign slow_cand = state_reg.slow_sel[SLOW_SRC_BIT] ?
                     xtal32k_level : rc32k_level;
  assign mic_cand = state_reg.slow_sel[MIC_SRC_BIT] ?
                    state_reg.slow_out : mic_if.clk_out;

  // Status word: switch activity and live clock levels
  assign status = {1'b0, state_reg.slow_src, state_reg.mic_src,
                   state_reg.slow_out, state_reg.mic_out,
                   audio_if.clk_out, fhs_busy, sys_busy};

  // Register writes, reads, dividers and glitch-free muxes
  always_comb
  begin
    state_next = state_reg;

    // Registers load on the completing access cycle
    if (wr_stb)
    begin
      case (idx)
        4'h0: state_next.gate_a = wbyte;
        4'h1: state_next.gate_b = wbyte;
        4'h2: state_next.gate_c = wbyte;
        4'h3: state_next.sys_sel = wbyte;
        4'h4: state_next.audio_step = wbyte;
        4'h5: state_next.audio_mod = wbyte;
        4'h6: state_next.mic_step = wbyte;
        4'h7: state_next.mic_mod = wbyte;
        4'h8: state_next.hs_high = wbyte;
        4'h9: state_next.slow_sel = wbyte;
        default: state_next.rdata = state_reg.rdata;
      endcase
    end

    // Read data is captured in the setup cycle, or late after a freeze
    if (psel && !(penable && state_reg.rd_fresh))
    begin
      state_next.rd_fresh = 1'b1;
      case (idx)
        4'h0: state_next.rdata = {24'h000000, state_reg.gate_a};
        4'h1: state_next.rdata = {24'h000000, state_reg.gate_b};
        4'h2: state_next.rdata = {24'h000000, state_reg.gate_c};
        4'h3: state_next.rdata = {24'h000000, state_reg.sys_sel};
        4'h4: state_next.rdata = {24'h000000, state_reg.audio_step};
        4'h5: state_next.rdata = {24'h000000, state_reg.audio_mod};
        4'h6: state_next.rdata = {24'h000000, state_reg.mic_step};
        4'h7: state_next.rdata = {24'h000000, state_reg.mic_mod};
        4'h8: state_next.rdata = {24'h000000, state_reg.hs_high};
        4'h9: state_next.rdata = {24'h000000, state_reg.slow_sel};
        4'ha: state_next.rdata = {24'h000000, status};
        default: state_next.rdata = 32'h00000000;
      endcase
    end

    // A completed access frees the capture for the next transfer
    if (psel && penable && pready)
      state_next.rd_fresh = 1'b0;

    // Divider count; new divisor taken only at an output edge
    if (hsdiv_tick)
    begin
      state_next.hs_cnt = 5'h00;
      state_next.hs_div = state_reg.sys_sel[DIV_LSB+4:DIV_LSB];
    end
    else if (high_speed_tick)
      state_next.hs_cnt = next_count(state_reg.hs_cnt);

    // Swallow counter for the 32 MHz option
    if (ref48_tick)
    begin
      if (state_reg.third_cnt == THIRD_LAST)
        state_next.third_cnt = 2'h0;
      else
        state_next.third_cnt = 2'(state_reg.third_cnt + 2'h1);
    end

    // Slow source changes only while both levels are low
    if (may_switch(state_reg.slow_src, state_reg.slow_sel[SLOW_SRC_BIT],
                   state_reg.slow_out, slow_cand))
      state_next.slow_src = state_reg.slow_sel[SLOW_SRC_BIT];
    state_next.slow_out = state_next.slow_src ?
                          xtal32k_level : rc32k_level;

    // Mic pin source changes only while both levels are low
    if (may_switch(state_reg.mic_src, state_reg.slow_sel[MIC_SRC_BIT],
                   state_reg.mic_out, mic_cand))
      state_next.mic_src = state_reg.slow_sel[MIC_SRC_BIT];
    state_next.mic_out = state_next.mic_src ?
                         state_reg.slow_out : mic_if.clk_out;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.gate_a <= RST_GATE_A;
      state_reg.gate_b <= RST_GATE_B;
      state_reg.gate_c <= RST_GATE_C;
      state_reg.sys_sel <= RST_SYS_SEL;
      state_reg.audio_step <= RST_AUDIO_STEP;
      state_reg.audio_mod <= RST_AUDIO_MOD;
      state_reg.mic_step <= RST_MIC_STEP;
      state_reg.mic_mod <= RST_MIC_MOD;
      state_reg.hs_high <= RST_HS_HIGH;
      state_reg.slow_sel <= RST_SLOW_SEL;
      state_reg.hs_div <= RST_HS_DIV;
    end
    else if (clock_en)
      state_reg <= state_next;
  end

  // Module clock gates: one enables, reserved bits never drive
  assign module_gate_a = state_reg.gate_a & GATE_A_MASK;
  assign module_gate_b = state_reg.gate_b & GATE_B_MASK;
  assign module_gate_c = state_reg.gate_c & GATE_C_MASK;

  // Clock outputs
  assign audio_clock = audio_if.clk_out;
  assign mic_clock = state_reg.mic_out;
  assign slow_clock = state_reg.slow_out;

endmodule : soc_clock_select_and_dividers

// [tb/clock_ctrl_assertions.sv]
`timescale 1ns/1ps
module clock_ctrl_checker
  import clock_ctrl_pkg::*;
(
  // Clock and bus
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Sources and outputs
  input wire logic rc24_tick,
  input wire logic xtal24_tick,
  input wire logic ref48_tick,
  input wire logic [7:0] module_gate_a,
  input wire logic [7:0] module_gate_b,
  input wire logic high_speed_tick,
  input wire logic system_tick,
  input wire logic audio_clock
);
  logic [7:0] sel_reg;
  logic hs_hi_reg;
  logic aud_en_reg;
  logic [5:0] calm_reg;
  logic [1:0] off_reg;
  logic wr;
  logic sel_wr;
  logic hs_want;
  // Write landing at this edge; expected high-speed source
  assign wr = psel && penable && pready && pwrite;
  assign sel_wr = wr && (paddr == 12'h198 || paddr == 12'h1c0);
  assign hs_want = hs_hi_reg ? xtal24_tick
    : (sel_reg[7] ? rc24_tick : ref48_tick);
  // Shadow settings; count calm cycles and low ticks while disabled
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sel_reg <= 8'h06;
      hs_hi_reg <= 1'b0;
      aud_en_reg <= 1'b0;
      calm_reg <= 6'h00;
      off_reg <= 2'h0;
    end
    else
    begin
      if (wr && paddr == 12'h198)
        sel_reg <= pwdata[7:0];
      if (wr && paddr == 12'h1c0)
        hs_hi_reg <= pwdata[0];
      if (wr && paddr == 12'h19c)
        aud_en_reg <= pwdata[7];
      if (sel_wr)
        calm_reg <= 6'h00;
      else if (calm_reg != 6'h3f)
        calm_reg <= calm_reg + 6'h01;
      if ((wr && paddr == 12'h19c) || audio_clock)
        off_reg <= 2'h0;
      else if (!aud_en_reg && ref48_tick && off_reg != 2'h2)
        off_reg <= off_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Switches have had time to finish
  sequence settled;
    calm_reg == 6'h3f && clock_en;
  endsequence
  a_gate_a_write: assert property (wr && paddr == 12'h18c |=>
    {24'h0, module_gate_a} == ($past(pwdata) & 32'hbf))
    else $error("gate a output wrong after write");
  a_gate_b_write: assert property (wr && paddr == 12'h190 |=>
    {24'h0, module_gate_b} == ($past(pwdata) & 32'h1f))
    else $error("gate b output wrong after write");
  a_audio_on_tick: assert property ($changed(audio_clock) |->
    $past(ref48_tick)) else $error("audio clock moved without ref tick");
  a_audio_held_off: assert property (off_reg == 2'h2 |->
    !audio_clock) else $error("audio clock runs while disabled");
  a_sys_rc_path: assert property (settled ##0 sel_reg[6:5] == 2'b00
    |-> system_tick == rc24_tick) else $error("system not on rc 24");
  a_sys_hs_path: assert property (settled ##0 sel_reg[6:5] == 2'b01
    |-> system_tick == high_speed_tick) else $error("system not on hs");
  a_sys_div_path: assert property (settled ##0 sel_reg[6:5] == 2'b10
    ##0 system_tick |-> high_speed_tick) else $error("divider tick odd");
  a_sys_32m_path: assert property (settled ##0 sel_reg[6:5] == 2'b11
    ##0 system_tick |-> ref48_tick) else $error("32 MHz tick odd");
  a_hs_source: assert property (settled |->
    high_speed_tick == hs_want) else $error("high-speed source wrong");
  a_hs_no_runt: assert property (high_speed_tick |=>
    !high_speed_tick) else $error("high-speed ticks too close");
  a_sys_no_runt: assert property (system_tick |=>
    !system_tick) else $error("system ticks too close");
endmodule : clock_ctrl_checker
bind soc_clock_select_and_dividers clock_ctrl_checker chk (.clock, .rst,
  .clock_en, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
  .rc24_tick, .xtal24_tick, .ref48_tick, .module_gate_a, .module_gate_b,
  .high_speed_tick, .system_tick, .audio_clock);

// [tb/test_soc_clock_select_and_dividers.sv]
`timescale 1ns/1ps
module test_soc_clock_select_and_dividers
  import clock_ctrl_pkg::*;
;
  logic clock, rst, clock_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rc24_tick, xtal24_tick, ref48_tick, rc32k_level, xtal32k_level;
  logic high_speed_tick, system_tick, audio_clock, mic_clock, slow_clock;
  logic [7:0] module_gate_a, module_gate_b, module_gate_c;
  logic err;
  logic [11:0] cyc;
  int n_errors, compares, n_sys, n_hs, n_aud, n_mic, n_slow;
  logic [9:0] idx [10] = '{IDX_GATE_A, IDX_GATE_B, IDX_GATE_C,
    IDX_SYS_SEL, IDX_AUDIO_STEP, IDX_AUDIO_MOD, IDX_MIC_STEP,
    IDX_MIC_MOD, IDX_HS_HIGH, IDX_SLOW_SEL};
  logic [31:0] rv [10] = '{32'h83, 32'h00, 32'h30, 32'h06, 32'h00,
    32'h02, 32'h01, 32'h02, 32'h00, 32'h04};
  // Select, high bit, expected system and high-speed ticks per window
  logic [31:0] tab [9] = '{32'h20003c3c, 32'ha0002828, 32'h20011e1e,
    32'ha0011e1e, 32'h4300143c, 32'h46000a3c, 32'h42001e3c,
    32'h6000283c, 32'h0600283c};

  soc_clock_select_and_dividers uut (.clock, .rst, .clock_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rc24_tick, .xtal24_tick, .ref48_tick, .rc32k_level, .xtal32k_level,
    .module_gate_a, .module_gate_b, .module_gate_c, .high_speed_tick,
    .system_tick, .audio_clock, .mic_clock, .slow_clock);

  // Clock at 40 MHz
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Periodic sources repeating every 120 cycles
  always @(posedge clock)
  begin
    cyc <= (cyc == 12'd119) ? 12'd0 : cyc + 12'd1;
    ref48_tick <= cyc % 2 == 0;
    rc24_tick <= cyc % 3 == 0;
    xtal24_tick <= cyc % 4 == 0;
    rc32k_level <= cyc % 20 < 10;
    xtal32k_level <= cyc % 12 < 6;
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; read data and error land in rd and err
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    xfer({i, 2'b00}, 1'b1, d);
  endtask : wr

  // Let switches settle, then count ticks and toggles over 120 cycles
  task automatic measure;
    logic a, m, s;
    n_sys = 0;
    n_hs = 0;
    n_aud = 0;
    n_mic = 0;
    n_slow = 0;
    repeat (40) @(posedge clock);
    @(negedge clock);
    {a, m, s} = {audio_clock, mic_clock, slow_clock};
    repeat (120)
    begin
      @(negedge clock);
      n_sys += system_tick;
      n_hs += high_speed_tick;
      n_aud += audio_clock != a;
      n_mic += mic_clock != m;
      n_slow += slow_clock != s;
      {a, m, s} = {audio_clock, mic_clock, slow_clock};
    end
  endtask : measure

  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    {rst, clock_en, psel, penable, pwrite} = 5'b11000;
    {paddr, pwdata, cyc} = '0;
    {rc24_tick, xtal24_tick, ref48_tick} = 3'b000;
    {rc32k_level, xtal32k_level} = 2'b00;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      xfer({idx[k], 2'b00}, 1'b0, 8'h00);
      chk(rd, rv[k]);
    end
    for (int k = 0; k < 3; k++)
      wr(idx[k], 8'hff);
    xfer({IDX_GATE_B, 2'b00}, 1'b0, 8'h00);
    chk({module_gate_c, module_gate_b, module_gate_a, rd[7:0]},
      32'h371fbfff);
    for (int k = 0; k < 3; k++)
      wr(idx[k], 8'h00);
    @(negedge clock);
    chk({module_gate_c, module_gate_b, module_gate_a}, 24'h0);
    xfer({10'h069, 2'b00}, 1'b1, 8'h55);
    chk(err, 1'b1);
    xfer(12'h18d, 1'b0, 8'h00);
    chk({err, rd}, {1'b1, 32'h0});
    wr(IDX_GATE_B, 8'h15);
    // Freeze across a read: ready must wait and data still arrive
    clock_en <= 1'b0;
    fork
      xfer({IDX_GATE_B, 2'b00}, 1'b0, 8'h00);
      begin
        repeat (6) @(posedge clock);
        chk(pready, 1'b0);
        clock_en <= 1'b1;
      end
    join
    chk({module_gate_b, rd[7:0]}, 16'h1515);
    for (int k = 0; k < 9; k++)
    begin
      wr(IDX_HS_HIGH, tab[k][23:16]);
      wr(IDX_SYS_SEL, tab[k][31:24]);
      measure;
      chk(n_sys, tab[k][15:8]);
      chk(n_hs, tab[k][7:0]);
    end
    wr(IDX_AUDIO_MOD, 8'h04);
    wr(IDX_AUDIO_STEP, 8'h81);
    wr(IDX_MIC_MOD, 8'h08);
    wr(IDX_MIC_STEP, 8'h82);
    measure;
    chk({n_aud, n_mic, n_slow}, {32'd30, 32'd30, 32'd12});
    wr(IDX_AUDIO_MOD, 8'h08);
    wr(IDX_AUDIO_STEP, 8'h84);
    wr(IDX_MIC_STEP, 8'h83);
    measure;
    chk({n_aud, n_mic}, {32'd60, 32'd45});
    wr(IDX_AUDIO_STEP, 8'h04);
    wr(IDX_MIC_STEP, 8'h03);
    wr(IDX_SLOW_SEL, 8'h05);
    measure;
    chk({n_aud, n_mic, n_slow}, {32'd0, 32'd0, 32'd20});
    chk({audio_clock, mic_clock}, 2'b00);
    wr(IDX_SLOW_SEL, 8'h07);
    measure;
    chk(n_mic, 32'd20);
    wr(IDX_SLOW_SEL, 8'h06);
    measure;
    chk({n_mic, n_slow}, {32'd12, 32'd12});
    xfer({IDX_STATUS, 2'b00}, 1'b0, 8'h00);
    chk(rd & 32'he7, 32'h20);
    end_of_test;
  end

  // Watchdog against a hung transfer
  initial
  begin
    #1000000;
    n_errors++;
    end_of_test;
  end
endmodule : test_soc_clock_select_and_dividers
